// [dv/ecs_top_props.sv]
`timescale 1ns/1ps
`include "ecs_cfg.svh"

// ----------------------------------------------------------------
// port checks for ecs_top
// ----------------------------------------------------------------
module ecs_top_props (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [`ECS_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_nmi,
    input wire logic i_tick_event,
    input wire ecs_pkg::ecs_core_evt_s i_core_evt,
    input wire ecs_pkg::ecs_irq_view_s i_irq_view,
    input wire logic o_nmi_request,
    input wire logic o_dsv_pending,
    input wire logic o_tick_pending,
    input wire logic [`ECS_NUM_W-1:0] o_highest_pending_number,
    input wire logic [`ECS_NUM_W-1:0] o_active_exception_number,
    input wire logic o_irq_clear_valid,
    input wire logic [`ECS_IRQ_IDX_W-1:0] o_irq_clear_index
);
    import ecs_pkg::*;
    logic wr_ok;
    logic dsv_wr;
    logic rd_ok;
    // accepted writes to the one mapped word and accepted reads at any address; only lane 3 holds writable bits
    assign wr_ok = i_avs_write && !o_avs_waitrequest && (i_avs_address == `ECS_OFF_STATE) && i_avs_byteenable[3];
    assign dsv_wr = wr_ok && i_avs_writedata[`ECS_BIT_DSV_SET];
    assign rd_ok = i_avs_read && !o_avs_waitrequest;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_req_waiting;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_ack_once;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    a_bus_one_wait: assert property (s_req_waiting |=> s_ack_once)
        else $error("waitrequest not low for exactly one cycle");
    a_nmi_write_set: assert property (wr_ok && i_avs_writedata[`ECS_BIT_NMI_SET] |=> o_nmi_request)
        else $error("nmi pending not set by write");
    a_dsv_write_set: assert property (dsv_wr |=> o_dsv_pending)
        else $error("deferred pending not set by write");
    a_dsv_write_clr: assert property (wr_ok && i_avs_writedata[27] && !i_avs_writedata[28] |=> !o_dsv_pending)
        else $error("deferred pending not cleared by write");
    a_dsv_only_write: assert property ($rose(o_dsv_pending) |-> $past(dsv_wr))
        else $error("deferred pending rose without a write");
    a_tick_write_set: assert property (wr_ok && i_avs_writedata[`ECS_BIT_TICK_SET] |=> o_tick_pending)
        else $error("tick pending not set by write");
    a_tick_write_clr: assert property (wr_ok && i_avs_writedata[25] && !i_avs_writedata[26] && !i_tick_event
        |=> !o_tick_pending)
        else $error("tick pending not cleared by write");
    a_enter_active: assert property (i_core_evt.enter
        |=> o_active_exception_number == $past(i_core_evt.enter_num))
        else $error("active number not taken from entry");
    a_irq_clear_pulse: assert property (i_core_evt.enter && i_core_evt.enter_num >= `ECS_NUM_IRQ0
        |=> o_irq_clear_valid && ({1'b0, o_irq_clear_index} == $past(i_core_evt.enter_num) - `ECS_NUM_IRQ0))
        else $error("entry did not clear the external pending state");
    a_reserved_zero: assert property (rd_ok |-> (o_avs_readdata & 32'h6BBC_0FC0) == 32'h0)
        else $error("reserved or write-only bits read nonzero");
    // pend must be settled for two cycles, since the read value is taken from registered state
    a_any_pending: assert property (rd_ok && $stable(i_irq_view.pend)
        && i_irq_view.pend == $past(i_irq_view.pend, 2) && i_avs_address == `ECS_OFF_STATE
        |-> o_avs_readdata[22] == (|i_irq_view.pend))
        else $error("any pending flag wrong");
endmodule : ecs_top_props

bind ecs_top ecs_top_props u_props (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_nmi(i_nmi), .i_tick_event(i_tick_event), .i_core_evt(i_core_evt), .i_irq_view(i_irq_view),
    .o_nmi_request(o_nmi_request), .o_dsv_pending(o_dsv_pending), .o_tick_pending(o_tick_pending),
    .o_highest_pending_number(o_highest_pending_number), .o_active_exception_number(o_active_exception_number),
    .o_irq_clear_valid(o_irq_clear_valid), .o_irq_clear_index(o_irq_clear_index));

// [dv/ecs_top_tb_top.sv]
`timescale 1ns/1ps
`include "ecs_cfg.svh"

module ecs_top_tb_top;
    import ecs_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] rdat;
    logic wait_req;
    logic nmi = 1'b0;
    logic tick = 1'b0;
    ecs_core_evt_s evt = '0;
    ecs_irq_view_s view = '0;
    logic nmi_req, dsv_p, tick_p, clr_v;
    logic [5:0] hpn, act;
    logic [4:0] clr_i;
    logic [31:0] rd;
    int n_mismatch = 0;
    int comparisons = 0;

    ecs_top dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd_req),
        .i_avs_write(wr_req), .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wait_req), .i_nmi(nmi), .i_tick_event(tick), .i_core_evt(evt), .i_irq_view(view),
        .o_nmi_request(nmi_req), .o_dsv_pending(dsv_p), .o_tick_pending(tick_p), .o_highest_pending_number(hpn),
        .o_active_exception_number(act), .o_irq_clear_valid(clr_v), .o_irq_clear_index(clr_i));

    // ------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------
    always #5 i_core_clk = ~i_core_clk;

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // master holds the request until it samples waitrequest low; only the watchdog ends a dead wait
    task automatic bus_wait();
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (wait_req !== 1'b0);
        check("wait edges", 32'h2, 32'(n));
    endtask : bus_wait

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge i_core_clk);
        adr <= a;
        wdat <= d;
        be <= b;
        wr_req <= 1'b1;
        bus_wait();
        wr_req <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        adr <= a;
        rd_req <= 1'b1;
        bus_wait();
        d = rdat;
        rd_req <= 1'b0;
    endtask : bus_read

    // one-cycle handler entry; the clear pulse only follows external entries
    task automatic enter_evt(input logic [5:0] num);
        @(posedge i_core_clk);
        evt.enter <= 1'b1;
        evt.enter_num <= num;
        @(posedge i_core_clk);
        evt.enter <= 1'b0;
        #1;
        check("active number", 32'(num), 32'(act));
        if (num >= `ECS_NUM_IRQ0) begin
            check("clear valid", 32'h1, 32'(clr_v));
            check("clear index", 32'(num - 6'h10), 32'(clr_i));
            @(posedge i_core_clk);
            #1;
            check("clear valid end", 32'h0, 32'(clr_v));
        end
    endtask : enter_evt

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // watchdog: the sequence needs well under a thousand cycles
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge i_core_clk);
        n_mismatch++;
        results();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1;
        check("active after reset", 32'h0, 32'(act));
        bus_read(`ECS_OFF_STATE, rd);
        check("state after reset", 32'h0, rd);
        bus_write(4'h0, 32'h1000_0000, 4'hF);
        bus_read(4'h0, rd);
        check("unmapped read", 32'h0, rd);
        check("unmapped write", 32'h0, 32'(dsv_p));
        // non-maskable: set, enter, then the signal rises inside the handler
        bus_write(`ECS_OFF_STATE, 32'h8000_0000, 4'hF);
        #1;
        check("nmi request", 32'h1, 32'(nmi_req));
        bus_read(`ECS_OFF_STATE, rd);
        check("nmi bit", 32'h1, 32'(rd[31]));
        check("highest nmi", 32'(`ECS_NUM_NMI), 32'(rd[17:12]));
        enter_evt(`ECS_NUM_NMI);
        bus_read(`ECS_OFF_STATE, rd);
        check("nmi after entry", 32'h0, 32'(rd[31]));
        check("active field", 32'(`ECS_NUM_NMI), 32'(rd[5:0]));
        nmi <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        bus_read(`ECS_OFF_STATE, rd);
        check("nmi signal again", 32'h1, 32'(rd[31]));
        enter_evt(`ECS_NUM_NMI);
        // return to thread mode before the next scenario
        @(posedge i_core_clk);
        nmi <= 1'b0;
        evt.leave <= 1'b1;
        evt.leave_num <= `ECS_NUM_NONE;
        @(posedge i_core_clk);
        evt.leave <= 1'b0;
        #1;
        check("back to thread", 32'h0, 32'(act));
        // deferred-service and tick; lane 3 disabled first, so nothing may change
        bus_write(`ECS_OFF_STATE, 32'h1400_0000, 4'h7);
        #1;
        check("lane off", 32'h0, 32'({dsv_p, tick_p}));
        bus_write(`ECS_OFF_STATE, 32'h1000_0000, 4'hF);
        bus_write(`ECS_OFF_STATE, 32'h0000_0000, 4'hF);
        bus_read(`ECS_OFF_STATE, rd);
        check("dsv set", 32'h1000_0000 | 32'(`ECS_NUM_DSV) << 12, rd);
        bus_write(`ECS_OFF_STATE, 32'h0400_0000, 4'hF);
        bus_read(`ECS_OFF_STATE, rd);
        check("tick set", 32'h1400_0000 | 32'(`ECS_NUM_DSV) << 12, rd);
        bus_write(`ECS_OFF_STATE, 32'h0800_0000, 4'hF);
        bus_read(`ECS_OFF_STATE, rd);
        check("dsv clear", 32'h0400_0000 | 32'(`ECS_NUM_TICK) << 12, rd);
        bus_write(`ECS_OFF_STATE, 32'h0200_0000, 4'hF);
        bus_read(`ECS_OFF_STATE, rd);
        check("tick clear", 32'h0, rd);
        @(posedge i_core_clk);
        tick <= 1'b1;
        @(posedge i_core_clk);
        tick <= 1'b0;
        #1;
        check("tick event", 32'h1, 32'({dsv_p, tick_p}));
        bus_write(`ECS_OFF_STATE, 32'h0200_0000, 4'hF);
        // external interrupts: pending but disabled, then enabled, lowest index wins
        view.pend <= 32'h0000_0028;
        repeat (3) @(posedge i_core_clk);
        bus_read(`ECS_OFF_STATE, rd);
        check("disabled pending", 32'h0040_0000, rd);
        view.en <= 32'h0000_0028;
        repeat (3) @(posedge i_core_clk);
        bus_read(`ECS_OFF_STATE, rd);
        check("enabled pending", 32'h0040_0000 | 32'h13 << 12, rd);
        check("highest out", 32'h13, 32'(hpn));
        enter_evt(6'h13);
        enter_evt(6'h2F);
        @(posedge i_core_clk);
        view.pend <= 32'h0;
        repeat (3) @(posedge i_core_clk);
        bus_read(`ECS_OFF_STATE, rd);
        check("none pending", 32'h0000_002F, rd);
        results();
    end
endmodule : ecs_top_tb_top

// [include/ecs_cfg.svh]
`ifndef ECS_CFG_SVH
`define ECS_CFG_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define ECS_ADDR_W 4
`define ECS_OFF_STATE 4'h4
`define ECS_STATE_RST 32'h0000_0000

// ----------------------------------------------------------------
// field positions of exception_control_state
// ----------------------------------------------------------------
`define ECS_BIT_NMI_SET 31
`define ECS_BIT_DSV_SET 28
`define ECS_BIT_DSV_CLR 27
`define ECS_BIT_TICK_SET 26
`define ECS_BIT_TICK_CLR 25
`define ECS_BIT_ANY_PEND 22
`define ECS_HPN_HI 17
`define ECS_HPN_LO 12
`define ECS_ACT_HI 5
`define ECS_ACT_LO 0

// ----------------------------------------------------------------
// exception numbers and sizes
// ----------------------------------------------------------------
`define ECS_NUM_W 6
`define ECS_NUM_NONE 6'h00
`define ECS_NUM_NMI 6'h02
`define ECS_NUM_DSV 6'h0E
`define ECS_NUM_TICK 6'h0F
`define ECS_NUM_IRQ0 6'h10
`define ECS_NIRQ 32
`define ECS_IRQ_IDX_W 5

`endif

// [include/ecs_pkg.sv]
package ecs_pkg;

    // ------------------------------------------------------------
    // core sequencer events, one-cycle pulses with their numbers
    // ------------------------------------------------------------
    typedef struct packed {
        logic enter;
        logic [5:0] enter_num;
        logic leave;
        logic [5:0] leave_num;
    } ecs_core_evt_s;

    // ------------------------------------------------------------
    // external interrupt view from the interrupt array
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] pend;
        logic [31:0] en;
    } ecs_irq_view_s;

    // ------------------------------------------------------------
    // register bus handshake state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ECS_BUS_WAIT = 1'b0,
        ECS_BUS_ACK = 1'b1
    } ecs_bus_e;

endpackage : ecs_pkg

// [src/ecs_pend_bit.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// one sticky pending flag, set beats clear
// ----------------------------------------------------------------
module ecs_pend_bit (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_set,
    input wire logic i_clr,
    output logic o_pend
);

    logic pend_ff;

    // an event landing in the clearing cycle must not be lost
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_ff <= 1'b0;
        end else if (i_set) begin
            pend_ff <= 1'b1;
        end else if (i_clr) begin
            pend_ff <= 1'b0;
        end
    end

    assign o_pend = pend_ff;

endmodule : ecs_pend_bit

// [src/ecs_top.sv]
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ecs_cfg.svh"

module ecs_top (
    input wire logic i_core_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [`ECS_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // core and interrupt array
    input wire logic i_nmi,
    input wire logic i_tick_event,
    input wire ecs_pkg::ecs_core_evt_s i_core_evt,
    input wire ecs_pkg::ecs_irq_view_s i_irq_view,
    output logic o_nmi_request,
    output logic o_dsv_pending,
    output logic o_tick_pending,
    output logic [`ECS_NUM_W-1:0] o_highest_pending_number,
    output logic [`ECS_NUM_W-1:0] o_active_exception_number,
    output logic o_irq_clear_valid,
    output logic [`ECS_IRQ_IDX_W-1:0] o_irq_clear_index
);

    import ecs_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ecs_bus_e bus_state_ff;
    ecs_bus_e nxt_bus_state;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic nmi_meta_ff;
    logic nmi_sync_ff;
    logic nmi_prev_ff;
    logic nmi_rise;
    logic wr_commit;
    logic sel_state;
    logic be_top;
    logic waitreq_ff;
    logic nxt_waitreq;
    logic sw_nmi_set;
    logic sw_dsv_set;
    logic sw_dsv_clr;
    logic sw_tick_set;
    logic sw_tick_clr;
    logic enter_nmi;
    logic enter_dsv;
    logic enter_tick;
    logic enter_irq;
    logic nmi_pend;
    logic dsv_pend;
    logic tick_pend;
    logic any_pend_ff;
    logic nxt_any_pend;
    logic [`ECS_NUM_W-1:0] hpn_ff;
    logic [`ECS_NUM_W-1:0] nxt_hpn;
    logic [`ECS_NUM_W-1:0] active_ff;
    logic [`ECS_NUM_W-1:0] nxt_active;
    logic irq_clr_valid_ff;
    logic [`ECS_IRQ_IDX_W-1:0] irq_clr_index_ff;
    logic [`ECS_NUM_W-1:0] irq_rel_num;
    logic [31:0] irq_ready;

    // ------------------------------------------------------------
    // register bus handshake
    // ------------------------------------------------------------

    // one wait cycle per access keeps read data a flop output;
    // the master samples waitrequest low at the next edge
    always_comb begin
        nxt_bus_state = ECS_BUS_WAIT;
        if ((i_avs_read || i_avs_write) && (bus_state_ff == ECS_BUS_WAIT)) begin
            nxt_bus_state = ECS_BUS_ACK;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_state_ff <= ECS_BUS_WAIT;
        end else begin
            bus_state_ff <= nxt_bus_state;
        end
    end

    // waitrequest has a flop of its own so the bus never sees a
    // decode glitch; it drops exactly when the state moves to ACK
    assign nxt_waitreq = (nxt_bus_state == ECS_BUS_WAIT);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            waitreq_ff <= 1'b1;
        end else begin
            waitreq_ff <= nxt_waitreq;
        end
    end

    assign o_avs_waitrequest = waitreq_ff;
    assign sel_state = (i_avs_address == `ECS_OFF_STATE);

    // a write lands only at the edge where waitrequest is seen low
    assign wr_commit = i_avs_write && (bus_state_ff == ECS_BUS_ACK) && sel_state;

    // the byte lane carrying the writable bits
    assign be_top = i_avs_byteenable[3];

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------

    // lanes 0..2 hold only read-only or reserved bits, so
    // nothing is written through them and they are not decoded

    // only the set and clear bits are looked at; every other bit
    // of the write word is dropped
    assign sw_nmi_set = wr_commit && be_top && i_avs_writedata[`ECS_BIT_NMI_SET];
    assign sw_dsv_set = wr_commit && be_top && i_avs_writedata[`ECS_BIT_DSV_SET];
    assign sw_dsv_clr = wr_commit && be_top && i_avs_writedata[`ECS_BIT_DSV_CLR];
    assign sw_tick_set = wr_commit && be_top && i_avs_writedata[`ECS_BIT_TICK_SET];
    assign sw_tick_clr = wr_commit && be_top && i_avs_writedata[`ECS_BIT_TICK_CLR];

    // ------------------------------------------------------------
    // non-maskable input
    // ------------------------------------------------------------

    // two-flop synchroniser, then a rising-edge detector on the
    // second stage only
    // i_nmi is a pin, so the first stage may go metastable
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            nmi_meta_ff <= 1'b0;
            nmi_sync_ff <= 1'b0;
            nmi_prev_ff <= 1'b0;
        end else begin
            nmi_meta_ff <= i_nmi;
            nmi_sync_ff <= nmi_meta_ff;
            nmi_prev_ff <= nmi_sync_ff;
        end
    end

    // a new assertion during the handler pends it again
    assign nmi_rise = nmi_sync_ff && !nmi_prev_ff;

    // ------------------------------------------------------------
    // handler entry decode
    // ------------------------------------------------------------
    assign enter_nmi = i_core_evt.enter && (i_core_evt.enter_num == `ECS_NUM_NMI);
    assign enter_dsv = i_core_evt.enter && (i_core_evt.enter_num == `ECS_NUM_DSV);
    assign enter_tick = i_core_evt.enter && (i_core_evt.enter_num == `ECS_NUM_TICK);
    assign enter_irq = i_core_evt.enter && (i_core_evt.enter_num >= `ECS_NUM_IRQ0);

    // ------------------------------------------------------------
    // pending flags
    // ------------------------------------------------------------

    // non-maskable: software write or a rising signal sets, entry clears
    ecs_pend_bit u_nmi_pend (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_set(sw_nmi_set || nmi_rise),
        .i_clr(enter_nmi),
        .o_pend(nmi_pend)
    );

    // deferred service: the software write is its only source;
    // set beats clear when both arrive in one write
    ecs_pend_bit u_dsv_pend (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_set(sw_dsv_set),
        .i_clr(sw_dsv_clr || enter_dsv),
        .o_pend(dsv_pend)
    );

    // system tick: the timer event or software sets it;
    // a timer pulse in the clearing cycle still pends it
    ecs_pend_bit u_tick_pend (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_set(sw_tick_set || i_tick_event),
        .i_clr(sw_tick_clr || enter_tick),
        .o_pend(tick_pend)
    );

    // the core starts the handler from this request right away
    assign o_nmi_request = nmi_pend;
    assign o_dsv_pending = dsv_pend;
    assign o_tick_pending = tick_pend;

    // ------------------------------------------------------------
    // external interrupt summary
    // ------------------------------------------------------------

    // the non-maskable exception is kept out of the summary flag
    // disabled interrupts count too: pending needs no enable
    assign nxt_any_pend = |i_irq_view.pend;
    assign irq_ready = i_irq_view.pend & i_irq_view.en;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            any_pend_ff <= 1'b0;
        end else begin
            any_pend_ff <= nxt_any_pend;
        end
    end

    // ------------------------------------------------------------
    // highest pending enabled exception
    // ------------------------------------------------------------

    // fixed priority: lower exception number wins, the
    // non-maskable one always first; the scan runs downward so
    // the last hit is the lowest index
    always_comb begin
        nxt_hpn = `ECS_NUM_NONE;
        for (int i = `ECS_NIRQ - 1; i >= 0; i--) begin
            if (irq_ready[i]) begin
                nxt_hpn = `ECS_NUM_IRQ0 + `ECS_NUM_W'(i);
            end
        end
        if (tick_pend) begin
            nxt_hpn = `ECS_NUM_TICK;
        end
        if (dsv_pend) begin
            nxt_hpn = `ECS_NUM_DSV;
        end
        if (nmi_pend) begin
            nxt_hpn = `ECS_NUM_NMI;
        end
    end

    // registered, so it trails the flags by one cycle
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hpn_ff <= `ECS_NUM_NONE;
        end else begin
            hpn_ff <= nxt_hpn;
        end
    end

    assign o_highest_pending_number = hpn_ff;

    // ------------------------------------------------------------
    // active exception tracking
    // ------------------------------------------------------------

    // the core reports the number it returns to; zero is thread mode
    // entry wins when entry and return land in one cycle
    always_comb begin
        nxt_active = active_ff;
        if (i_core_evt.enter) begin
            nxt_active = i_core_evt.enter_num;
        end else if (i_core_evt.leave) begin
            nxt_active = i_core_evt.leave_num;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            active_ff <= `ECS_NUM_NONE;
        end else begin
            active_ff <= nxt_active;
        end
    end

    assign o_active_exception_number = active_ff;

    // ------------------------------------------------------------
    // external interrupt pending clear on entry
    // ------------------------------------------------------------

    // index is the exception number less sixteen, as software sees it
    assign irq_rel_num = i_core_evt.enter_num - `ECS_NUM_IRQ0;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_clr_valid_ff <= 1'b0;
            irq_clr_index_ff <= '0;
        end else begin
            irq_clr_valid_ff <= enter_irq;
            if (enter_irq) begin
                irq_clr_index_ff <= irq_rel_num[`ECS_IRQ_IDX_W-1:0];
            end
        end
    end

    assign o_irq_clear_valid = irq_clr_valid_ff;
    assign o_irq_clear_index = irq_clr_index_ff;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------

    // built from the flags before any write of this same access
    // lands; clear bits and reserved ranges read as zero and an
    // unmapped address reads all zero
    always_comb begin
        nxt_rdata = `ECS_STATE_RST;
        if (sel_state) begin
            nxt_rdata[`ECS_BIT_NMI_SET] = nmi_pend;
            nxt_rdata[`ECS_BIT_DSV_SET] = dsv_pend;
            nxt_rdata[`ECS_BIT_TICK_SET] = tick_pend;
            nxt_rdata[`ECS_BIT_TICK_CLR] = 1'b0;
            nxt_rdata[`ECS_BIT_ANY_PEND] = any_pend_ff;
            nxt_rdata[`ECS_HPN_HI:`ECS_HPN_LO] = hpn_ff;
            nxt_rdata[`ECS_ACT_HI:`ECS_ACT_LO] = active_ff;
        end
    end

    // captured on the wait cycle, held through the answer edge;
    // a write leaves the last read word standing
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= `ECS_STATE_RST;
        end else if (i_avs_read && (bus_state_ff == ECS_BUS_WAIT)) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_avs_readdata = rdata_ff;

endmodule : ecs_top
